// [hw/stm_pkg.sv]
package stm_pkg;
   // register offsets inside the register file page
   localparam logic [7:0] OFF_CNT_HIGH = 8'hf0;
   localparam logic [7:0] OFF_CNT_LOW  = 8'hf1;
   localparam logic [7:0] OFF_PRESC    = 8'hf2;
   localparam logic [7:0] OFF_CTRL     = 8'hf3;

   // values after reset
   localparam logic [15:0] RST_COUNT = 16'hffff;
   localparam logic [7:0]  RST_PRESC = 8'hff;
   localparam logic [7:0]  RST_CTRL  = 8'h14;
   // synchroniser idle levels: interrupt pin low, event pin and reference high
   localparam logic [2:0]  RST_SYNC  = 3'b011;

   // control register field positions
   localparam int CTL_RUN    = 7;
   localparam int CTL_SINGLE = 6;
   localparam int CTL_INM_HI = 5;
   localparam int CTL_INM_LO = 4;
   localparam int CTL_INPUT_SECTION_ENABLE   = 3;
   localparam int CTL_INTSEL = 2;
   localparam int CTL_OUT_HI = 1;
   localparam int CTL_OUT_LO = 0;

   // internal clock divider ahead of the prescaler
   localparam int          INT_DIV     = 4;
   localparam logic [1:0]  INT_DIV_TOP = 2'h3;

   typedef enum logic [1:0] {
      STM_IN_EVENT   = 2'b00,
      STM_IN_GATED   = 2'b01,
      STM_IN_TRIG    = 2'b10,
      STM_IN_RETRIG  = 2'b11
   } stm_in_mode_t;
endpackage : stm_pkg

// [hw/stm_presc_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface stm_presc_if;
   logic       tick;     // one input clock period of the prescaler
   logic       restart;  // clear the internal count
   logic [7:0] divValue; // programmed prescaler value, the divide ratio minus one
   logic       done;     // one full division period completed

   modport timer (output tick, output restart, output divValue, input done);
   modport presc (input tick, input restart, input divValue, output done);
endinterface : stm_presc_if
`default_nettype wire

// [hw/stm_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module stm_prescaler (
   input  wire logic  clk,
   input  wire logic  rst_n,
   stm_presc_if.presc p
);
   logic [7:0] count_q;
   logic       done_q;

   // counts ticks up to the live value, so a new value acts at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= 8'h00;
      end else if (p.restart) begin
         count_q <= 8'h00;
      end else if (p.tick) begin
         // [R05] divide by value plus one
         if (count_q >= p.divValue) begin
            count_q <= 8'h00;
         end else begin
            count_q <= count_q + 8'h01;
         end
      end
   end

   // one pulse per completed period
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
      end else begin
         done_q <= p.tick && !p.restart && (count_q >= p.divValue);
      end
   end

   assign p.done = done_q;

   property p_presc_zero;
      @(posedge clk) disable iff (!rst_n)
      (p.tick && !p.restart && p.divValue == 8'h00) |=> p.done;
   endproperty
   a_presc_zero : assert property (p_presc_zero) // [R05]
      else $error("prescaler value zero did not pass every tick");
endmodule : stm_prescaler
`default_nettype wire

// [hw/stm_timer.sv]
// How it works
// [R01] counter high byte register holds bits 15:8, resets to all ones
// [R02] counter low byte register holds bits 7:0, resets to all ones
// [R03] counter byte writes set reload constant; reads return live count
// [R04] prescaler register reads back the programmed value, not internal count
// [R05] prescaler divides by value plus one; zero means no division
// [R06] control register resets with only input enable and interrupt select set; code resets it to 14h, setting input mode bit 4 and interrupt select
// [R07] control bit 7 starts counting when 1, stops when 0
// [R08] control bit 6 picks continuous (0) or single (1) mode
// [R09] bits 5:4 pick event, gated, triggerable or retriggerable input mode
// [R10] bit 3 enables input section; software keeps it 0 without inputs
// [R11] bit 2 low routes timer interrupt, high routes external interrupt pin
// [R12] bits 1:0 pick no output, square wave, or pwm output
// [R13] end of count when the counter underflows at zero; interrupt per end
// [R14] single mode stops, reloads, clears run; continuous reloads and continues
// [R15] input disabled counts internal clock over four, ignores mode and pin
// [R16] square wave toggles at each end; pwm copies low mode bit
// [R17] counter decrements once per completed prescaler period while counting
// [R18] with no output mode the output pin is held high
`timescale 1ns/1ps
`default_nettype none
module stm_timer #(
   parameter logic USE_OSC_REF = 1'b0 // event source is the reference clock
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] regAddr,
   input  wire logic       regWrite,
   input  wire logic [7:0] regWdata,
   output logic      [7:0] regRdata,
   input  wire logic       timerInputPin,
   input  wire logic       oscillatorReferenceClock,
   input  wire logic       extIntPin,
   output logic            timerOutputPin,
   output logic            intChannel
);
   // refuse an unknown source select at elaboration
   if (USE_OSC_REF !== 1'b0 && USE_OSC_REF !== 1'b1) begin : g_bad_src
      $error("USE_OSC_REF must be 0 or 1");
   end

   stm_presc_if pif ();

   logic [15:0] count_q;
   logic [15:0] reload_q;
   logic        pending_q;
   logic [7:0]  presc_q;
   logic [7:0]  ctrl_q;
   logic        armed_q;
   logic [1:0]  div_q;
   logic [2:0]  sync1_q;
   logic [2:0]  sync2_q;
   logic        srcPrev_q;
   logic        out_q;
   logic        int_q;
   logic [7:0]  rdata_q;

   // input synchronisers reset to idle level, so no false edge or pulse
   logic [2:0] rawIn;
   assign rawIn = {extIntPin, oscillatorReferenceClock, timerInputPin};
   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            sync1_q[i] <= stm_pkg::RST_SYNC[i];
            sync2_q[i] <= stm_pkg::RST_SYNC[i];
         end else begin
            sync1_q[i] <= rawIn[i];
            sync2_q[i] <= sync1_q[i];
         end
      end
   end

   logic srcLevel;
   logic srcFall;
   logic extLevel;
   assign srcLevel = USE_OSC_REF ? sync2_q[1] : sync2_q[0];
   assign extLevel = sync2_q[2];
   assign srcFall  = srcPrev_q && !srcLevel;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         srcPrev_q <= 1'b1;
      end else begin
         srcPrev_q <= srcLevel;
      end
   end

   // register write decode
   logic wrHigh;
   logic wrLow;
   logic wrPresc;
   logic wrCtrl;
   assign wrHigh  = regWrite && (regAddr == stm_pkg::OFF_CNT_HIGH);
   assign wrLow   = regWrite && (regAddr == stm_pkg::OFF_CNT_LOW);
   assign wrPresc = regWrite && (regAddr == stm_pkg::OFF_PRESC);
   assign wrCtrl  = regWrite && (regAddr == stm_pkg::OFF_CTRL);

   logic                 runBit;
   logic                 inEnable;
   stm_pkg::stm_in_mode_t inMode;
   logic [1:0]           outMode;
   assign runBit   = ctrl_q[stm_pkg::CTL_RUN];
   assign inEnable = ctrl_q[stm_pkg::CTL_INPUT_SECTION_ENABLE];
   assign inMode   = stm_pkg::stm_in_mode_t'(ctrl_q[stm_pkg::CTL_INM_HI:stm_pkg::CTL_INM_LO]);
   assign outMode  = ctrl_q[stm_pkg::CTL_OUT_HI:stm_pkg::CTL_OUT_LO];

   // internal clock over four
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 2'h0;
      end else begin
         div_q <= div_q + 2'h1;
      end
   end

   logic intTick;
   assign intTick = (div_q == stm_pkg::INT_DIV_TOP);

   // input mode selects what feeds the prescaler
   logic srcTick;
   logic retrigger;
   always_comb begin
      srcTick   = intTick;
      retrigger = 1'b0;
      // [R10] input section gate
      if (inEnable) begin
         // [R09] input mode select
         unique case (inMode)
            stm_pkg::STM_IN_EVENT:  srcTick = srcFall;
            stm_pkg::STM_IN_GATED:  srcTick = intTick && srcLevel;
            stm_pkg::STM_IN_TRIG:   srcTick = intTick && armed_q;
            stm_pkg::STM_IN_RETRIG: begin
               srcTick   = intTick;
               retrigger = runBit && srcFall;
            end
         endcase
      end
   end

   // triggerable mode waits for a falling edge after the run bit is set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else if (!runBit) begin
         armed_q <= 1'b0;
      end else if (srcFall) begin
         armed_q <= 1'b1;
      end
   end

   logic startEdge;
   logic eoc;
   assign startEdge = wrCtrl && regWdata[stm_pkg::CTL_RUN] && !runBit;
   // [R13] underflow on a period finished at zero
   assign eoc = pif.done && runBit && (count_q == 16'h0000);

   // [R15] [R17] prescaler fed only while running
   assign pif.tick     = runBit && srcTick;
   assign pif.restart  = startEdge || retrigger;
   assign pif.divValue = presc_q;

   stm_prescaler u_presc (
      .clk   (clk),
      .rst_n (rst_n),
      .p     (pif.presc)
   );

   // [R01] [R02] reload constant bytes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reload_q <= stm_pkg::RST_COUNT;
      end else begin
         if (wrHigh) begin
            reload_q[15:8] <= regWdata;
         end
         if (wrLow) begin
            reload_q[7:0] <= regWdata;
         end
      end
   end

   // a constant written while stopped is taken at the next start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_q <= 1'b0;
      end else if (wrHigh || wrLow) begin
         pending_q <= 1'b1;
      end else if (startEdge || eoc || retrigger) begin
         pending_q <= 1'b0;
      end
   end

   // [R14] reload at end, start with new constant, or retrigger
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= stm_pkg::RST_COUNT;
      end else if (eoc || retrigger || (startEdge && pending_q)) begin
         count_q <= reload_q;
      end else if (pif.done && runBit) begin
         // [R17] one step per prescaler period
         count_q <= count_q - 16'h0001;
      end
   end

   // [R04] prescaler value acts at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         presc_q <= stm_pkg::RST_PRESC;
      end else if (wrPresc) begin
         presc_q <= regWdata;
      end
   end

   // [R06] [R07] [R08] control register; a software write beats the auto clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= stm_pkg::RST_CTRL;
      end else if (wrCtrl) begin
         ctrl_q <= regWdata;
      end else if (eoc && ctrl_q[stm_pkg::CTL_SINGLE]) begin
         // [R14] single mode clears run
         ctrl_q[stm_pkg::CTL_RUN] <= 1'b0;
      end
   end

   // [R12] [R16] [R18] output pin
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= 1'b1;
      end else if (outMode == 2'b00) begin
         out_q <= 1'b1;
      end else if (eoc) begin
         out_q <= outMode[1] ? outMode[0] : !out_q;
      end
   end

   // [R11] [R13] shared interrupt channel source
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_q <= 1'b0;
      end else if (ctrl_q[stm_pkg::CTL_INTSEL]) begin
         int_q <= extLevel;
      end else begin
         int_q <= eoc;
      end
   end

   // [R03] [R04] read mux, live count; unmapped reads zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else begin
         unique case (regAddr)
            stm_pkg::OFF_CNT_HIGH: rdata_q <= count_q[15:8];
            stm_pkg::OFF_CNT_LOW:  rdata_q <= count_q[7:0];
            stm_pkg::OFF_PRESC:    rdata_q <= presc_q;
            stm_pkg::OFF_CTRL:     rdata_q <= ctrl_q;
            default:               rdata_q <= 8'h00;
         endcase
      end
   end

   assign regRdata       = rdata_q;
   assign timerOutputPin = out_q;
   assign intChannel     = int_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_single_stop;
      (eoc && ctrl_q[stm_pkg::CTL_SINGLE] && !wrCtrl) |=> !runBit;
   endproperty
   a_single_stop : assert property (p_single_stop) // [R14]
      else $error("single mode did not clear run at end of count");

   property p_cont_run;
      (eoc && !ctrl_q[stm_pkg::CTL_SINGLE] && !wrCtrl) |=> runBit && count_q == $past(reload_q);
   endproperty
   a_cont_run : assert property (p_cont_run) // [R14]
      else $error("continuous mode did not reload and keep running");

   property p_decrement;
      (pif.done && runBit && count_q != 16'h0000 && !retrigger && !startEdge)
         |=> count_q == $past(count_q) - 16'h0001;
   endproperty
   a_decrement : assert property (p_decrement) // [R17]
      else $error("counter did not step down by one");

   property p_stopped_hold;
      (!runBit && !startEdge) |=> $stable(count_q);
   endproperty
   a_stopped_hold : assert property (p_stopped_hold) // [R07]
      else $error("counter moved while stopped");

   property p_no_output;
      (outMode == 2'b00) |=> timerOutputPin;
   endproperty
   a_no_output : assert property (p_no_output) // [R18]
      else $error("output not high with no output mode");

   property p_square;
      (eoc && outMode == 2'b01) |=> timerOutputPin != $past(timerOutputPin);
   endproperty
   a_square : assert property (p_square) // [R16]
      else $error("square wave did not toggle");

   property p_pwm;
      (eoc && outMode[1]) |=> timerOutputPin == $past(outMode[0]);
   endproperty
   a_pwm : assert property (p_pwm) // [R16]
      else $error("pwm output did not copy mode bit");

   property p_int_timer;
      (!ctrl_q[stm_pkg::CTL_INTSEL]) |=> intChannel == $past(eoc);
   endproperty
   a_int_timer : assert property (p_int_timer) // [R11]
      else $error("timer interrupt not on channel");

   property p_int_ext;
      (ctrl_q[stm_pkg::CTL_INTSEL]) |=> intChannel == $past(extLevel);
   endproperty
   a_int_ext : assert property (p_int_ext) // [R11]
      else $error("external pin not on channel");

   property p_presc_read;
      (regAddr == stm_pkg::OFF_PRESC) |=> regRdata == $past(presc_q);
   endproperty
   a_presc_read : assert property (p_presc_read) // [R04]
      else $error("prescaler read did not return programmed value");

   property p_input_section_enable_off;
      (!inEnable && runBit && !intTick) |-> !pif.tick;
   endproperty
   a_input_section_enable_off : assert property (p_input_section_enable_off) // [R15]
      else $error("disabled input section fed a non internal tick");

   c_eoc_single : cover property (eoc && ctrl_q[stm_pkg::CTL_SINGLE]);
   c_retrigger  : cover property (retrigger);
   c_pwm_eoc    : cover property (eoc && outMode[1]);
   c_event_tick : cover property (inEnable && inMode == stm_pkg::STM_IN_EVENT && pif.tick);
endmodule : stm_timer
`default_nettype wire

// [tb/standard_timer_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module standard_timer_regs_tb;
   logic       clk;
   logic       rst_n;
   logic [7:0] regAddr;
   logic       regWrite;
   logic [7:0] regWdata;
   logic [7:0] regRdata;
   logic       pinIn;
   logic       oscRef;
   logic       extPin;
   logic       outPin;
   logic       intChannel;
   int         n_fail;
   int         checks;
   int         nInt;
   int         cyc;
   int         n;
   logic [7:0] rA;
   logic [7:0] rB;
   logic       lvl;

   // clock and pulse tally
   initial clk = 1'b0;
   always #5 clk = ~clk;
   // counted on the falling edge, where the pulse has settled
   always @(negedge clk) if (intChannel === 1'b1) nInt++;

   stm_timer dut_u (
      .clk                      (clk),
      .rst_n                    (rst_n),
      .regAddr                  (regAddr),
      .regWrite                 (regWrite),
      .regWdata                 (regWdata),
      .regRdata                 (regRdata),
      .timerInputPin            (pinIn),
      .oscillatorReferenceClock (oscRef),
      .extIntPin                (extPin),
      .timerOutputPin           (outPin),
      .intChannel               (intChannel)
   );
   stm_pin_src src_u (
      .clk                      (clk),
      .timerInputPin            (pinIn),
      .oscillatorReferenceClock (oscRef),
      .extIntPin                (extPin)
   );

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // hang guard; a normal run needs about a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8
   task automatic chkN(input string nm, input int e, input int g);
      checks++;
      if (g != e) begin
         n_fail++;
         $display("wrong value %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chkN

   // one write cycle; strobe drops a full cycle later
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
   endtask : wr
   // read data lands one cycle after the address
   task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      @(negedge clk);
      d = regRdata;
   endtask : rdReg
   task automatic chkRd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rdReg(a, d);
      chk8($sformatf("reg%h", a), e, d);
   endtask : chkRd
   // live low byte either moves or holds over 40 cycles
   task automatic moved(input string nm, input logic e);
      logic [7:0] a;
      logic [7:0] b;
      // let steps already in flight through the synchroniser land first
      repeat (4) @(negedge clk);
      rdReg(8'hf1, a);
      repeat (40) @(negedge clk);
      rdReg(8'hf1, b);
      chk8(nm, {7'h00, e}, {7'h00, a !== b});
   endtask : moved
   task automatic waitInt(output int k);
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (intChannel !== 1'b1 && k < 3000);
      // a missing pulse is a mismatch, not a silent pass
      if (intChannel !== 1'b1) begin
         n_fail++;
         $display("wrong value intWait expected 1 seen 0");
      end
   endtask : waitInt
   // first wait absorbs a phase left over from a setting change
   task automatic period(input int e);
      waitInt(n);
      waitInt(n);
      chkN("eocPeriod", e, n);
   endtask : period

   initial begin
      rst_n = 1'b0;
      regAddr = 8'h00;
      regWrite = 1'b0;
      regWdata = 8'h00;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      chk8("outPin", 8'h01, {7'h00, outPin}); // idle high
      chkRd(8'hf0, 8'hff); // high byte
      chkRd(8'hf1, 8'hff); // low byte
      chkRd(8'hf2, 8'hff); // prescaler
      chkRd(8'hf3, 8'h14); // control
      wr(8'hf4, 8'h55);
      chkRd(8'hf4, 8'h00); // unmapped stays zero
      wr(8'hf2, 8'h00);
      chkRd(8'hf2, 8'h00); // readback
      // internal clock run from the reset constant
      wr(8'hf3, 8'h80);
      moved("runCount", 1'b1); // live count
      wr(8'hf3, 8'h00);
      moved("stopHold", 1'b0); // stopped
      chkRd(8'hf0, 8'hff); // high byte live
      // input section on with the pin present
      wr(8'hf3, 8'h98);
      moved("gateHigh", 1'b1); // gated runs
      src_u.setLevel(1'b0);
      moved("gateLow", 1'b0); // gated holds
      src_u.setLevel(1'b1);
      wr(8'hf3, 8'h00);
      wr(8'hf3, 8'ha8);
      moved("trigWait", 1'b0); // waits for trigger
      src_u.fallEdge();
      moved("trigRun", 1'b1); // triggered
      // event counting: reload 1 needs two edges per end of count
      wr(8'hf3, 8'h00);
      wr(8'hf0, 8'h00);
      wr(8'hf1, 8'h01);
      wr(8'hf3, 8'h88);
      moved("evtIdle", 1'b0); // no internal clock
      n = nInt;
      src_u.fallEdge();
      src_u.fallEdge();
      chkN("evtEoc", n + 1, nInt); // event count
      // internal clock over four, period (reload+1)*4*(presc+1)
      wr(8'hf3, 8'h00);
      wr(8'hf1, 8'h03);
      wr(8'hf3, 8'h80);
      period(16);
      wr(8'hf2, 8'h01);
      period(32); // divide by two
      wr(8'hf2, 8'h00);
      // output modes; the level is kept apart from the wait count
      wr(8'hf3, 8'h81);
      waitInt(n);
      lvl = outPin;
      waitInt(n);
      chk8("square", {7'h00, ~lvl}, {7'h00, outPin}); // toggle
      wr(8'hf3, 8'h82);
      waitInt(n);
      chk8("pwmLow", 8'h00, {7'h00, outPin}); // pwm copy
      wr(8'hf3, 8'h83);
      waitInt(n);
      chk8("pwmHigh", 8'h01, {7'h00, outPin}); // pwm copy
      wr(8'hf3, 8'h80);
      repeat (3) @(negedge clk);
      chk8("noOut", 8'h01, {7'h00, outPin}); // held high
      // single mode stops and reloads at end of count
      wr(8'hf3, 8'hc0);
      waitInt(n);
      repeat (2) @(negedge clk);
      chkRd(8'hf3, 8'h40); // run cleared
      chkRd(8'hf1, 8'h03); // reloaded
      moved("singleStop", 1'b0); // stays stopped
      // retriggerable: a falling edge while running reloads the constant
      wr(8'hf1, 8'h40);
      wr(8'hf3, 8'hb8);
      repeat (100) @(negedge clk);
      rdReg(8'hf1, rA);
      src_u.fallEdge();
      rdReg(8'hf1, rB);
      chk8("retrig", 8'h01, {7'h00, rB > rA}); // reload on edge
      // interrupt channel source select
      wr(8'hf3, 8'h04);
      src_u.setExt(1'b1);
      repeat (4) @(negedge clk);
      chk8("extRoute", 8'h01, {7'h00, intChannel}); // pin routed
      wr(8'hf3, 8'h00);
      repeat (4) @(negedge clk);
      chk8("extBlock", 8'h00, {7'h00, intChannel}); // pin masked
      src_u.setExt(1'b0);
      tally_and_finish();
   end
endmodule : standard_timer_regs_tb
`default_nettype wire

// [tb/stm_pin_src.sv]
`timescale 1ns/1ps
`default_nettype none
// far-side pin source; the input line idles high like a pulled-up pin
module stm_pin_src (
   input  wire logic clk,
   output logic      timerInputPin,
   output logic      oscillatorReferenceClock,
   output logic      extIntPin
);
   initial begin
      timerInputPin = 1'b1;
      oscillatorReferenceClock = 1'b0;
      extIntPin = 1'b0;
   end
   // free-running reference, unused while the design keeps USE_OSC_REF off
   always begin
      repeat (5) @(negedge clk);
      oscillatorReferenceClock = ~oscillatorReferenceClock;
   end
   task automatic setLevel(input logic v);
      @(negedge clk);
      timerInputPin = v;
   endtask : setLevel
   // spaced falling edge
   // spacing covers the synchroniser plus the minimum event gap
   task automatic fallEdge();
      setLevel(1'b0);
      repeat (8) @(negedge clk);
      setLevel(1'b1);
      repeat (8) @(negedge clk);
   endtask : fallEdge
   task automatic setExt(input logic v);
      @(negedge clk);
      extIntPin = v;
   endtask : setExt
endmodule : stm_pin_src
`default_nettype wire
